// File: src/pmx_pkg.sv
// pmx_pkg: constants and carrier types for the shared drop-bus / line-clock pins
package pmx_pkg;

  // register map, byte addresses on the 16-bit microprocessor address space
  localparam logic [15:0] PMX_CH4_IOCTL_ADDR = 16'h5f01;
  localparam logic [15:0] PMX_CH8_IOCTL_ADDR = 16'h9f01;

  // io control field layout
  localparam int unsigned PMX_IOCTL_EDGE_BIT = 0;
  localparam int unsigned PMX_IOCTL_STS1_BIT = 1;
  localparam logic [7:0]  PMX_IOCTL_RESET    = 8'h00;
  localparam logic [7:0]  PMX_IOCTL_MASK     = 8'h03;
  localparam logic [7:0]  PMX_RDATA_NONE     = 8'h00;

  // data path and line clock sizes
  localparam int unsigned PMX_DROP_W     = 8;
  localparam int unsigned PMX_FIFO_DEPTH = 16;
  localparam int unsigned PMX_NUM_LINE   = 2;
  localparam int unsigned PMX_LINE_HALF  = 2;

  // register request from the microprocessor interface
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pmx_reg_req_t;

  // register answer, one cycle after a read strobe
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } pmx_reg_rsp_t;

  // one line-interface channel as seen at the pins
  typedef struct packed {
    logic clk;
    logic data;
  } pmx_line_t;

endpackage

// File: src/pmx_pin_mux.sv
// pmx_pin_mux: drop-bus upper bits shared with line clock outputs, plus the drop fifo

// dual-clock fifo with gray pointers; the read side stalls to give back-pressure
module pmx_afifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  // write side
  input  wire logic         wclk,
  input  wire logic         wrst_n,
  input  wire logic         w_valid,
  input  wire logic [W-1:0] w_data,
  output logic              w_ready,
  // read side
  input  wire logic         rclk,
  input  wire logic         rrst_n,
  output logic              r_valid,
  output logic [W-1:0]      r_data,
  input  wire logic         r_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wbin_r;
  logic [AW:0]  wgray_r;
  logic [AW:0]  rq1_r;
  logic [AW:0]  rq2_r;
  logic [AW:0]  rbin_r;
  logic [AW:0]  rgray_r;
  logic [AW:0]  wq1_r;
  logic [AW:0]  wq2_r;
  logic [AW:0]  wbin_nxt;
  logic [AW:0]  rbin_nxt;
  logic         w_fire;
  logic         r_fire;

  assign w_fire   = w_valid & w_ready;
  assign r_fire   = r_valid & r_ready;
  assign wbin_nxt = wbin_r + (AW+1)'(w_fire);
  assign rbin_nxt = rbin_r + (AW+1)'(r_fire);
  // full when the far pointer differs only in its two top gray bits
  assign w_ready  = wgray_r != {~rq2_r[AW:AW-1], rq2_r[AW-2:0]};
  assign r_valid  = rgray_r != wq2_r;
  assign r_data   = mem_r[rbin_r[AW-1:0]];

  always_ff @(posedge wclk) begin
    if (w_fire) begin
      mem_r[wbin_r[AW-1:0]] <= w_data;
    end
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_r  <= '0;
      wgray_r <= '0;
      rq1_r   <= '0;
      rq2_r   <= '0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      rq1_r   <= rgray_r;
      rq2_r   <= rq1_r;
    end
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_r  <= '0;
      rgray_r <= '0;
      wq1_r   <= '0;
      wq2_r   <= '0;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      wq1_r   <= wgray_r;
      wq2_r   <= wq1_r;
    end
  end
endmodule

// Notes on behaviour
// - bus enabled: drop bits; disabled: line clocks
// - pin six is drop bus bit six
// - pin seven is drop bus msb
// - drop bus changes on drop clock rise
// - bus disabled: pins carry channel line clocks
// - line data updates on clock rise by default
// - channel four edge bit selects falling update
// - channel eight edge bit selects falling update
// - sts-1 mode ignores edge bit, always rising
module pmx_pin_mux #(
  parameter int unsigned LINE_HALF  = pmx_pkg::PMX_LINE_HALF,
  parameter int unsigned FIFO_DEPTH = pmx_pkg::PMX_FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  // drop bus clock from the telecom bus receiver
  input  wire logic                 drop_bus0_clock,
  // register access
  input  wire pmx_pkg::pmx_reg_req_t reg_req,
  output pmx_pkg::pmx_reg_rsp_t     reg_rsp,
  // telecom bus enable strap for channel 0
  input  wire logic                 tbus0_enable,
  // drop byte stream from the framer side
  input  wire logic                 drop_valid,
  input  wire logic [7:0]           drop_byte,
  output logic                      drop_ready,
  // serial line data from the channel 4 and 8 framers
  input  wire logic                 line_src_ch4,
  input  wire logic                 line_src_ch8,
  // device pins
  output logic                      drop_bus0_bit6,
  output logic                      drop_bus0_bit7,
  output logic [5:0]                drop_bus0_low,
  output logic                      line_data_out_ch4,
  output logic                      line_data_out_ch8
);
  import pmx_pkg::*;

  localparam int unsigned CW = (LINE_HALF > 1) ? $clog2(LINE_HALF) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(LINE_HALF - 1);

  // ---------------- register file ----------------
  logic [7:0]             ioctl_r [PMX_NUM_LINE];
  logic [PMX_NUM_LINE-1:0] hit;
  logic [7:0]             rd_mux;
  pmx_reg_rsp_t           rsp_r;

  assign hit[0] = reg_req.addr == PMX_CH4_IOCTL_ADDR;
  assign hit[1] = reg_req.addr == PMX_CH8_IOCTL_ADDR;
  // unmapped addresses read as zero
  assign rd_mux = hit[0] ? ioctl_r[0] : (hit[1] ? ioctl_r[1] : PMX_RDATA_NONE);
  assign reg_rsp = rsp_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ack   <= reg_req.rd;
      rsp_r.rdata <= reg_req.rd ? rd_mux : PMX_RDATA_NONE;
    end
  end

  // ---------------- bus enable synchronisers ----------------
  logic tb_s1_r;
  logic tb_s2_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tb_s1_r <= 1'b0;
      tb_s2_r <= 1'b0;
    end else begin
      tb_s1_r <= tbus0_enable;
      tb_s2_r <= tb_s1_r;
    end
  end

  // ---------------- line clock and data channels ----------------
  logic [PMX_NUM_LINE-1:0] src;
  logic [PMX_NUM_LINE-1:0] src_s1_r;
  logic [PMX_NUM_LINE-1:0] src_r;
  logic [PMX_NUM_LINE-1:0] lclk_r;
  logic [PMX_NUM_LINE-1:0] ldat_r;
  logic [PMX_NUM_LINE-1:0] tick;
  logic [PMX_NUM_LINE-1:0] rise;
  logic [PMX_NUM_LINE-1:0] fall;
  logic [PMX_NUM_LINE-1:0] use_fall;
  logic [PMX_NUM_LINE-1:0] upd;

  assign src = {line_src_ch8, line_src_ch4};

  // framer bits arrive on clk_sys; two stages align them with the divider
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      src_s1_r <= '0;
      src_r    <= '0;
    end else begin
      src_s1_r <= src;
      src_r    <= src_s1_r;
    end
  end

  for (genvar i = 0; i < PMX_NUM_LINE; i++) begin : g_line
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    assign tick[i]  = cnt_r == CNT_LAST;
    assign cnt_nxt  = tick[i] ? '0 : cnt_r + CW'(1);
    assign rise[i]  = tick[i] & ~lclk_r[i];
    assign fall[i]  = tick[i] & lclk_r[i];
    assign use_fall[i] = ioctl_r[i][PMX_IOCTL_EDGE_BIT] & ~ioctl_r[i][PMX_IOCTL_STS1_BIT];
    assign upd[i] = use_fall[i] ? fall[i] : rise[i];

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        ioctl_r[i] <= PMX_IOCTL_RESET;
      end else if (reg_req.wr && hit[i]) begin
        ioctl_r[i] <= reg_req.wdata & PMX_IOCTL_MASK;
      end
    end

    // the line clock is divided down here, so it shares clk_sys
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        cnt_r     <= '0;
        lclk_r[i] <= 1'b0;
        ldat_r[i] <= 1'b0;
      end else begin
        cnt_r     <= cnt_nxt;
        lclk_r[i] <= lclk_r[i] ^ tick[i];
        ldat_r[i] <= upd[i] ? src_r[i] : ldat_r[i];
      end
    end
  end

  assign line_data_out_ch4 = ldat_r[0];
  assign line_data_out_ch8 = ldat_r[1];

  // ---------------- drop bus domain ----------------
  logic       drst_s1_r;
  logic       drop_rst_n;
  logic       tbd_s1_r;
  logic       tbd_s2_r;
  logic       f_valid;
  logic [7:0] f_data;
  logic       d_fire;
  logic [7:0] dbyte_r;

  // reset asserts at once and releases on the drop clock
  always_ff @(posedge drop_bus0_clock or negedge arst_n) begin
    if (!arst_n) begin
      drst_s1_r  <= 1'b0;
      drop_rst_n <= 1'b0;
    end else begin
      drst_s1_r  <= 1'b1;
      drop_rst_n <= drst_s1_r;
    end
  end

  always_ff @(posedge drop_bus0_clock or negedge drop_rst_n) begin
    if (!drop_rst_n) begin
      tbd_s1_r <= 1'b0;
      tbd_s2_r <= 1'b0;
    end else begin
      tbd_s1_r <= tbus0_enable;
      tbd_s2_r <= tbd_s1_r;
    end
  end

  // drained only while the bus is enabled, so the fifo fills when it is off
  pmx_afifo #(
    .W     (PMX_DROP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wclk    (clk_sys),
    .wrst_n  (arst_n),
    .w_valid (drop_valid),
    .w_data  (drop_byte),
    .w_ready (drop_ready),
    .rclk    (drop_bus0_clock),
    .rrst_n  (drop_rst_n),
    .r_valid (f_valid),
    .r_data  (f_data),
    .r_ready (tbd_s2_r)
  );

  assign d_fire = f_valid & tbd_s2_r;

  always_ff @(posedge drop_bus0_clock or negedge drop_rst_n) begin
    if (!drop_rst_n) begin
      dbyte_r <= '0;
    end else if (d_fire) begin
      dbyte_r <= f_data;
    end
  end

  // ---------------- shared pins ----------------
  // the select follows the synchronised strap; a glitch is possible on the switch itself
  // select by bus enable
  assign drop_bus0_bit6 = tb_s2_r ? dbyte_r[6] : lclk_r[0];
  assign drop_bus0_bit7 = tb_s2_r ? dbyte_r[7] : lclk_r[1];
  assign drop_bus0_low  = dbyte_r[5:0];

  // ---------------- assertions ----------------
  sequence s_rise4;
    rise[0] && !use_fall[0];
  endsequence

  sequence s_fall4;
    fall[0] && ioctl_r[0][PMX_IOCTL_EDGE_BIT] && !ioctl_r[0][PMX_IOCTL_STS1_BIT];
  endsequence

  sequence s_fall8;
    fall[1] && ioctl_r[1][PMX_IOCTL_EDGE_BIT] && !ioctl_r[1][PMX_IOCTL_STS1_BIT];
  endsequence

  AST_PIN6_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tb_s2_r |-> drop_bus0_bit6 == dbyte_r[6])
    else $error("pin six not drop bit six while bus enabled");

  AST_PIN7_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tb_s2_r |-> drop_bus0_bit7 == dbyte_r[7])
    else $error("pin seven not drop msb while bus enabled");

  AST_PIN_CLK: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !tb_s2_r |-> drop_bus0_bit6 == lclk_r[0] && drop_bus0_bit7 == lclk_r[1])
    else $error("line clocks missing from pins while bus disabled");

  AST_PIN_SWITCH: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(tb_s2_r) |-> drop_bus0_bit6 == dbyte_r[6] && drop_bus0_bit7 == dbyte_r[7])
    else $error("pins did not follow bus enable");

  AST_DROP_UPD: assert property (@(posedge drop_bus0_clock) disable iff (!drop_rst_n)
    d_fire |=> dbyte_r == $past(f_data) && drop_bus0_low == $past(f_data[5:0]))
    else $error("drop byte not taken on drop clock rise");

  AST_DROP_HOLD: assert property (@(posedge drop_bus0_clock) disable iff (!drop_rst_n)
    !tbd_s2_r |=> $stable(dbyte_r))
    else $error("drop byte moved while bus disabled");

  AST_RISE4: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_rise4 |=> lclk_r[0] && line_data_out_ch4 == $past(src_r[0]))
    else $error("channel 4 data not updated on clock rise");

  AST_FALL4: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_fall4 |=> !lclk_r[0] && line_data_out_ch4 == $past(src_r[0]))
    else $error("channel 4 data not updated on clock fall");

  AST_FALL8: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_fall8 |=> !lclk_r[1] && line_data_out_ch8 == $past(src_r[1]))
    else $error("channel 8 data not updated on clock fall");

  AST_STS1: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (fall[1] && ioctl_r[1][PMX_IOCTL_STS1_BIT]) |=> $stable(line_data_out_ch8))
    else $error("channel 8 data moved on fall in sts-1 mode");

endmodule

// File: testbench/pmx_drop_partner.sv
// pmx_drop_partner: drop bus receiver model, makes the drop clock and samples the byte
module pmx_drop_partner (
  // bench control, stall stops the drop clock
  input  wire logic       stall,
  // drop bus pins
  output logic            drop_bus0_clock,
  input  wire logic       drop_bus0_bit6,
  input  wire logic       drop_bus0_bit7,
  input  wire logic [5:0] drop_bus0_low,
  // captured byte
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    drop_bus0_clock = 1'b0;
    #11;
    forever begin
      #62.5;
      if (!stall) begin
        drop_bus0_clock = ~drop_bus0_clock;
      end
    end
  end
  // msb order, mid-cycle sample
  // pins move on the rise, so the fall sees a settled byte
  // the start delay skips the time-zero clock step, which is no real edge
  initial begin
    rx_byte = 8'h00;
    #1;
    forever begin
      @(negedge drop_bus0_clock);
      rx_byte <= {drop_bus0_bit7, drop_bus0_bit6, drop_bus0_low};
    end
  end
endmodule

// File: testbench/drop_bus_upper_bits_clock_out_mux_tb_top.sv
// drop_bus_upper_bits_clock_out_mux_tb_top: self-checking bench for the pin mux
module drop_bus_upper_bits_clock_out_mux_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pmx_pkg::*;
  logic         clk_sys, arst_n, drop_bus0_clock, tbus0_enable, stall;
  pmx_reg_req_t reg_req;
  pmx_reg_rsp_t reg_rsp;
  logic         drop_valid, drop_ready, line_src_ch4, line_src_ch8;
  logic [7:0]   drop_byte, rx_byte, last_b, tg, tg0;
  logic         drop_bus0_bit6, drop_bus0_bit7, line_data_out_ch4, line_data_out_ch8;
  logic [5:0]   drop_bus0_low;
  logic         p6, p7, pd4, pd8, lchk, exp_rise;
  logic [7:0]   rq[$];
  logic [7:0]   dq[$];
  int           miscompares, comparisons;

  pmx_pin_mux #(.LINE_HALF(2), .FIFO_DEPTH(16)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .drop_bus0_clock(drop_bus0_clock), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .tbus0_enable(tbus0_enable), .drop_valid(drop_valid), .drop_byte(drop_byte),
    .drop_ready(drop_ready), .line_src_ch4(line_src_ch4), .line_src_ch8(line_src_ch8),
    .drop_bus0_bit6(drop_bus0_bit6), .drop_bus0_bit7(drop_bus0_bit7),
    .drop_bus0_low(drop_bus0_low), .line_data_out_ch4(line_data_out_ch4),
    .line_data_out_ch8(line_data_out_ch8));
  pmx_drop_partner partner_u (.stall(stall), .drop_bus0_clock(drop_bus0_clock),
    .drop_bus0_bit6(drop_bus0_bit6), .drop_bus0_bit7(drop_bus0_bit7),
    .drop_bus0_low(drop_bus0_low), .rx_byte(rx_byte));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic give_up;
    miscompares++;
    print_verdict();
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_val(got, exp);
  endtask
  task automatic cmp_drop(input logic [7:0] got, input logic [7:0] exp);
    cmp_val(got, exp);
  endtask
  task automatic cmp_line(input logic [7:0] got, input logic [7:0] exp);
    cmp_val(got, exp);
  endtask
  // register access, entered just after a rising edge
  task automatic reg_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    if (!w) rq.push_back(d);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
    @(posedge clk_sys);
  endtask
  // request held until ready is seen high at the taking edge
  task automatic push(input logic [7:0] b, input int lim, output bit ok);
    ok = 1'b0;
    drop_valid <= 1'b1;
    drop_byte <= b;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge clk_sys);
      ok = (drop_ready === 1'b1);
      @(posedge clk_sys);
    end
    if (ok) dq.push_back(b);
  endtask
  // each byte differs from the one before, so every pop shows at the pins
  function automatic logic [7:0] nb();
    logic [7:0] b;
    b = 8'($urandom);
    if (b == last_b) b = ~b;
    last_b = b;
    return b;
  endfunction
  task automatic wait_drain;
    for (int n = 0; n < 8000 && dq.size() > 0; n++) @(posedge clk_sys);
    if (dq.size() > 0) give_up();
  endtask

  always @(posedge clk_sys) begin
    line_src_ch4 <= 1'($urandom);
    line_src_ch8 <= 1'($urandom);
  end
  always @(negedge clk_sys) begin
    if (reg_rsp.ack === 1'b1) begin
      cmp_reg(reg_rsp.rdata, (rq.size() > 0) ? rq.pop_front() : 8'hxx);
    end
  end
  always @(rx_byte) begin
    if (dq.size() > 0) cmp_drop(rx_byte, dq.pop_front());
  end
  // data may only move where the line clock just made the selected edge
  always @(negedge clk_sys) begin
    if (lchk) begin
      if (line_data_out_ch4 !== pd4) begin
        cmp_line(8'({p6, drop_bus0_bit6}), 8'({!exp_rise, exp_rise}));
      end
      if (line_data_out_ch8 !== pd8) begin
        cmp_line(8'({p7, drop_bus0_bit7}), 8'({!exp_rise, exp_rise}));
      end
    end
    // only this process writes the toggle count; scenarios take differences
    if (!arst_n) begin
      tg = 8'h00;
    end else begin
      tg = tg + 8'(drop_bus0_bit6 !== p6) + 8'(drop_bus0_bit7 !== p7);
    end
    {p6, p7, pd4, pd8} = {drop_bus0_bit6, drop_bus0_bit7, line_data_out_ch4, line_data_out_ch8};
  end

  initial begin
    bit ok;
    int n;
    void'($urandom(32'h6a0fd263));
    {arst_n, drop_valid, stall, lchk} = 4'h0;
    reg_req = '0;
    drop_byte = 8'h00;
    last_b = 8'h00;
    tg0 = 8'h00;
    {tbus0_enable, exp_rise} = 2'h3;
    // drop side flops clear at once and release on their own clock later
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    reg_acc(1'b0, PMX_CH4_IOCTL_ADDR, PMX_IOCTL_RESET);
    reg_acc(1'b0, PMX_CH8_IOCTL_ADDR, PMX_IOCTL_RESET);
    reg_acc(1'b1, 16'h5f00, 8'hff);
    reg_acc(1'b0, 16'h5f00, PMX_RDATA_NONE);
    reg_acc(1'b0, PMX_CH4_IOCTL_ADDR, PMX_IOCTL_RESET);
    // back to back bytes, drop side far slower than the writer
    // the first byte past the fifo depth waits for the drop side to leave reset, so the limit is wide
    repeat (20) begin
      push(nb(), 400, ok);
      if (!ok) give_up();
    end
    drop_valid <= 1'b0;
    wait_drain();
    repeat (100) @(posedge clk_sys);
    // stalled receiver: fifo fills to its depth and then refuses
    stall <= 1'b1;
    repeat (60) @(posedge clk_sys);
    tg0 = tg;
    n = 0;
    repeat (17) begin
      push(nb(), 30, ok);
      n += int'(ok);
    end
    drop_valid <= 1'b0;
    cmp_val(8'(n), 8'h10);
    cmp_val(8'(tg - tg0), 8'h00);
    @(posedge clk_sys);
    stall <= 1'b0;
    wait_drain();
    tbus0_enable <= 1'b0;
    repeat (100) @(posedge clk_sys);
    for (int m = 0; m < 4; m++) begin
      reg_acc(1'b1, PMX_CH4_IOCTL_ADDR, {6'($urandom), 2'(m)});
      reg_acc(1'b1, PMX_CH8_IOCTL_ADDR, {6'($urandom), 2'(m)});
      reg_acc(1'b0, PMX_CH4_IOCTL_ADDR, {6'h00, 2'(m)});
      reg_acc(1'b0, PMX_CH8_IOCTL_ADDR, {6'h00, 2'(m)});
      exp_rise = (m != 1);
      tg0 = tg;
      lchk = 1'b1;
      repeat (64) @(posedge clk_sys);
      lchk = 1'b0;
      cmp_val(8'(tg - tg0), 8'h40);
    end
    print_verdict();
  end
endmodule
